/* File: logic/pbpc_port.sv */
// Operation
// RQ1 - Eight pins, each independently input or output via direction bits.
// RQ2 - Every pin has a weak pull-up switched by its enable bit.
// RQ3 - Output pins always have their pull-up forced off.
// RQ4 - Power-on reset leaves all pull-ups disabled through the global disable.
// RQ5 - Option bit 7 set disables all pull-ups; clear uses individual bits.
// RQ6 - Only pins 7 to 4 support change interrupt, individually enabled.
// RQ7 - Power-on reset clears all change interrupt enables.
// RQ8 - Enabled change pins compare against latch captured at last port read.
// RQ9 - OR of enabled mismatches sets change flag, interrupt control bit 0.
// RQ10 - A port change event can wake the device from sleep.
// RQ11 - Any port access reloads latch; software then clears the flag.
// RQ12 - Persisting mismatch keeps setting the flag every cycle.
// RQ13 - Master-clear and brown-out keep latch; mismatch sets flag again.
// RQ14 - A change coinciding with a port read may be missed.
// RQ15 - Pin 7 carries programming data, pin 6 programming clock.
// RQ16 - Pin 0 is an edge-triggered external interrupt with its own flag.
// RQ17 - Option bit 6 picks the edge: 1 rising, 0 falling.
// RQ18 - Change request to core only while change flag and enable set.
`timescale 1ns/1ps
module pbpc_port #(
   parameter int WIDTH = 8
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic POR,
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic [7:0] PIN_IN,
   output logic [7:0] PIN_OUT,
   output logic [7:0] PIN_OE,
   output logic [7:0] PULLUP_ON,
   input wire logic PROG_MODE,
   input wire logic PROG_DATA_OUT,
   input wire logic PROG_DATA_OE,
   output logic PROG_DATA_IN,
   output logic PROG_CLOCK_IN,
   output logic CHG_IRQ,
   output logic EXT_IRQ,
   output logic WAKE,
   output logic IRQ
);
   initial begin
      if (WIDTH != 8) begin
         $error("pbpc_port serves only an 8-bit port");
      end
   end
   // ==========================================
   // Bus decode
   pbpc_pkg::pbpc_req_t req;
   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   function automatic logic hit(input pbpc_pkg::pbpc_req_t r, input logic [3:0] a);
      hit = r.addr == a;
   endfunction
   wire logic wr_port = req.wr & hit(req, pbpc_pkg::ADDR_PORT);
   wire logic rd_port = req.rd & hit(req, pbpc_pkg::ADDR_PORT);
   wire logic wr_dir = req.wr & hit(req, pbpc_pkg::ADDR_DIR);
   wire logic wr_pu = req.wr & hit(req, pbpc_pkg::ADDR_PULLUP);
   wire logic wr_opt = req.wr & hit(req, pbpc_pkg::ADDR_OPTION);
   wire logic wr_chg = req.wr & hit(req, pbpc_pkg::ADDR_CHGEN);
   wire logic wr_ic = req.wr & hit(req, pbpc_pkg::ADDR_INTCTL);
   wire logic wr_evclr = req.wr & hit(req, pbpc_pkg::ADDR_EVCLR);
   wire logic wr_even = req.wr & hit(req, pbpc_pkg::ADDR_EVEN);
   // ==========================================
   // Registers
   logic [7:0] out_q, dir_q, pu_q, opt_q, chg_q, ic_q, ev_q, even_q, rdata_q;
   logic [7:0] ic_d, ev_d, rdata_d;
   // RQ4 power-on defaults
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dir_q <= pbpc_pkg::RST_DIR;
         opt_q <= pbpc_pkg::RST_OPTION;
         pu_q <= pbpc_pkg::RST_PULLUP;
         chg_q <= pbpc_pkg::RST_ZERO;
         out_q <= pbpc_pkg::RST_ZERO;
         even_q <= pbpc_pkg::RST_ZERO;
      end else begin
         if (wr_dir) dir_q <= req.wdata;
         if (wr_pu) pu_q <= req.wdata;
         if (wr_opt) opt_q <= req.wdata;
         if (wr_chg) chg_q <= {req.wdata[7:4], 4'h0};
         if (wr_port) out_q <= req.wdata;
         if (wr_even) even_q <= {6'h00, req.wdata[1:0]};
         // RQ7 power-on clear
         if (POR) begin
            chg_q <= pbpc_pkg::RST_ZERO;
            opt_q <= pbpc_pkg::RST_OPTION;
         end
      end
   end
   // ==========================================
   // Pin drive
   // RQ1 per-pin direction
   assign PIN_OE = ~dir_q;
   assign PIN_OUT = out_q;
   // RQ2 RQ3 RQ5 pull-up gating
   assign PULLUP_ON = pu_q & dir_q & {8{~opt_q[pbpc_pkg::OPT_PU_DIS]}};
   // RQ15 programming pins
   assign PROG_DATA_IN = PROG_MODE & ~PROG_DATA_OE & PIN_IN[7];
   assign PROG_CLOCK_IN = PROG_MODE & PIN_IN[6];
   // ==========================================
   // Change detection
   logic [3:0] hold_q;
   // RQ11 RQ13 latch reload on access
   pbpc_latch #(.W(4)) u_hold (
      .clk(CLK),
      .load(wr_port | rd_port),
      .din(PIN_IN[7:4]),
      .q(hold_q)
   );
   // RQ6 RQ8 compare enabled pins
   wire logic [3:0] mism = (PIN_IN[7:4] ^ hold_q) & chg_q[7:4];
   // RQ9 RQ14 OR mismatches, suppressed during port read or write
   wire logic chg_set = (|mism) & ~(wr_port | rd_port);
   // RQ16 RQ17 external edge
   logic ext_hit;
   pbpc_edge u_edge (
      .clk(CLK),
      .rst(RST),
      .din(PIN_IN[0]),
      .rising(opt_q[pbpc_pkg::OPT_EDGE]),
      .hit(ext_hit)
   );
   // RQ12 set wins over clear
   always_comb begin
      ic_d = ic_q;
      if (wr_ic) ic_d = req.wdata & 8'h1B;
      if (chg_set) ic_d[pbpc_pkg::IC_CHG_FLAG] = 1'b1;
      if (ext_hit) ic_d[pbpc_pkg::IC_EXT_FLAG] = 1'b1;
   end
   always_comb begin
      ev_d = ev_q;
      if (wr_evclr) ev_d = ev_q & ~req.wdata;
      if (chg_set) ev_d[pbpc_pkg::EV_CHG] = 1'b1;
      if (ext_hit) ev_d[pbpc_pkg::EV_EXT] = 1'b1;
   end
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ic_q <= pbpc_pkg::RST_ZERO;
         ev_q <= pbpc_pkg::RST_ZERO;
      end else begin
         ic_q <= ic_d;
         ev_q <= ev_d;
      end
   end
   // RQ18 gated requests
   assign CHG_IRQ = ic_q[pbpc_pkg::IC_CHG_FLAG] & ic_q[pbpc_pkg::IC_CHG_EN];
   assign EXT_IRQ = ic_q[pbpc_pkg::IC_EXT_FLAG] & ic_q[pbpc_pkg::IC_EXT_EN];
   // RQ10 wake on change
   assign WAKE = CHG_IRQ;
   assign IRQ = |(ev_q & even_q);
   // ==========================================
   // Read back
   always_comb begin
      unique case (req.addr)
         pbpc_pkg::ADDR_PORT: rdata_d = (PIN_IN & dir_q) | (out_q & ~dir_q);
         pbpc_pkg::ADDR_DIR: rdata_d = dir_q;
         pbpc_pkg::ADDR_PULLUP: rdata_d = pu_q;
         pbpc_pkg::ADDR_OPTION: rdata_d = opt_q;
         pbpc_pkg::ADDR_CHGEN: rdata_d = chg_q;
         pbpc_pkg::ADDR_INTCTL: rdata_d = ic_q;
         pbpc_pkg::ADDR_EVSTAT: rdata_d = ev_q;
         pbpc_pkg::ADDR_EVEN: rdata_d = even_q;
         default: rdata_d = 8'h00;
      endcase
   end
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rdata_q <= pbpc_pkg::RST_ZERO;
      end else begin
         rdata_q <= req.rd ? rdata_d : 8'h00;
      end
   end
   assign RDATA = rdata_q;
   // ==========================================
   // Checks
   a_pullup_output_off: assert property (@(posedge CLK) disable iff (RST) // RQ3
      (PIN_OE & PULLUP_ON) == 8'h00) else $error("pull-up on for output pin");
   a_pullup_global_off: assert property (@(posedge CLK) disable iff (RST) // RQ5
      opt_q[7] |-> PULLUP_ON == 8'h00) else $error("pull-up on while globally off");
   a_mismatch_sets_flag: assert property (@(posedge CLK) disable iff (RST) // RQ9
      chg_set |=> ic_q[0]) else $error("change flag not set");
   a_flag_persists: assert property (@(posedge CLK) disable iff (RST) // RQ12
      (chg_set && wr_ic && !WDATA[0]) |=> ic_q[0]) else $error("clear beat mismatch");
   a_low_pins_no_chg: assert property (@(posedge CLK) disable iff (RST) // RQ6
      chg_q[3:0] == 4'h0) else $error("change enable on low pins");
   a_por_clears_en: assert property (@(posedge CLK) disable iff (RST) // RQ7
      POR |=> chg_q == 8'h00) else $error("enables survive power-on");
   a_ext_edge_flag: assert property (@(posedge CLK) disable iff (RST) // RQ17
      (opt_q[6] && $rose(PIN_IN[0])) |=> ic_q[1]) else $error("rising edge missed");
   a_irq_gating: assert property (@(posedge CLK) disable iff (RST) // RQ18
      CHG_IRQ == (ic_q[0] && ic_q[3])) else $error("change request gating wrong");
endmodule // pbpc_port

/* File: logic/pbpc_pkg.sv */
package pbpc_pkg;
   // ==========================================
   // Register indices
   localparam logic [3:0] ADDR_PORT = 4'h0;
   localparam logic [3:0] ADDR_DIR = 4'h1;
   localparam logic [3:0] ADDR_PULLUP = 4'h2;
   localparam logic [3:0] ADDR_OPTION = 4'h3;
   localparam logic [3:0] ADDR_CHGEN = 4'h4;
   localparam logic [3:0] ADDR_INTCTL = 4'h5;
   localparam logic [3:0] ADDR_EVSTAT = 4'h6;
   localparam logic [3:0] ADDR_EVCLR = 4'h7;
   localparam logic [3:0] ADDR_EVEN = 4'h8;
   // ==========================================
   // Field positions
   localparam int OPT_PU_DIS = 7;
   localparam int OPT_EDGE = 6;
   localparam int IC_CHG_FLAG = 0;
   localparam int IC_EXT_FLAG = 1;
   localparam int IC_CHG_EN = 3;
   localparam int IC_EXT_EN = 4;
   localparam int CHG_LO = 4;
   localparam int EV_CHG = 0;
   localparam int EV_EXT = 1;
   // ==========================================
   // Reset values
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_OPTION = 8'hFF;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_PULLUP = 8'hFF;
   // ==========================================
   // Bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pbpc_req_t;
endpackage

/* File: logic/pbpc_edge.sv */
`timescale 1ns/1ps
module pbpc_edge (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   input wire logic rising,
   output logic hit
);
   logic prev_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= din;
      end
   end
   assign hit = rising ? (din & ~prev_q) : (~din & prev_q);
endmodule // pbpc_edge

/* File: logic/pbpc_latch.sv */
`timescale 1ns/1ps
module pbpc_latch #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic load,
   input wire logic [W-1:0] din,
   output logic [W-1:0] q
);
   // Holding latch: no reset, survives master-clear and brown-out
   always_ff @(posedge clk) begin
      if (load) begin
         q <= din;
      end
   end
endmodule // pbpc_latch

/* File: sim/pbpc_pins.sv */
`timescale 1ns/1ps
// ====
// Circuitry outside the port pins
module pbpc_pins (
   input wire logic clk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pullup_on,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   output logic [7:0] pin_lvl
);
   logic [7:0] last_q = 8'h00;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                      pullup_on[i] ? 1'b1 : ~last_q[i];
      end
   end
   always_ff @(posedge clk) begin
      last_q <= pin_lvl;
   end
endmodule // pbpc_pins

/* File: sim/pbpc_port_bench.sv */
`timescale 1ns/1ps
module pbpc_port_bench;
   logic clk = 1'b0, rst = 1'b1, por = 1'b1, wr = 1'b0, rd = 1'b0, prog = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, ext_val = 8'h00, ext_en = 8'hFF;
   logic [7:0] rdata, pin_out, pin_oe, pu, lvl;
   logic pdi, pci, chg, ext, wake, irq;
   int bad_count = 0, n_compared = 0, cycles = 0;
   pbpc_port i_pbpc_port (.CLK(clk), .RST(rst), .POR(por), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(lvl), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
      .PULLUP_ON(pu), .PROG_MODE(prog), .PROG_DATA_OUT(1'b0), .PROG_DATA_OE(1'b0),
      .PROG_DATA_IN(pdi), .PROG_CLOCK_IN(pci), .CHG_IRQ(chg), .EXT_IRQ(ext), .WAKE(wake),
      .IRQ(irq));
   pbpc_pins i_pbpc_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pu),
      .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(lvl));
   // ====
   // Clock, watchdog, tasks
   initial forever #25 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(logic [3:0] a, logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk($sformatf("reg %h", a), exp, rdata);
   endtask
   // ====
   // Tests
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      #1 chk("pullup", 8'h00, pu); // all off
      rd_chk(pbpc_pkg::ADDR_OPTION, 8'hFF); // reset value
      rd_chk(pbpc_pkg::ADDR_CHGEN, 8'h00); // reset value
      rd_chk(4'hF, 8'h00); // unmapped
      wr_reg(pbpc_pkg::ADDR_OPTION, 8'h7F);
      wr_reg(pbpc_pkg::ADDR_PULLUP, 8'h0F);
      wr_reg(pbpc_pkg::ADDR_DIR, 8'hFC);
      #1 chk("pullup", 8'h0C, pu); // outputs off
      wr_reg(pbpc_pkg::ADDR_OPTION, 8'hFF);
      #1 chk("pullup", 8'h00, pu); // global off
      wr_reg(pbpc_pkg::ADDR_PORT, 8'hA5);
      wr_reg(pbpc_pkg::ADDR_DIR, 8'h00);
      #1 chk("oe", 8'hFF, pin_oe); // all driven
      rd_chk(pbpc_pkg::ADDR_PORT, 8'hA5); // output level
      wr_reg(pbpc_pkg::ADDR_DIR, 8'hFF);
      rd_chk(pbpc_pkg::ADDR_PORT, 8'h00); // latch load
      wr_reg(pbpc_pkg::ADDR_CHGEN, 8'hFF);
      rd_chk(pbpc_pkg::ADDR_CHGEN, 8'hF0); // upper pins only
      wr_reg(pbpc_pkg::ADDR_INTCTL, 8'h08);
      ext_val <= 8'h02;
      repeat (3) @(posedge clk);
      rd_chk(pbpc_pkg::ADDR_INTCTL, 8'h08); // low pin ignored
      ext_val <= 8'h22;
      repeat (3) @(posedge clk);
      rd_chk(pbpc_pkg::ADDR_INTCTL, 8'h09); // flag set
      #1 chk("wake", 8'h03, {6'h00, wake, chg}); // request
      wr_reg(pbpc_pkg::ADDR_EVEN, 8'h01);
      #1 chk("irq", 8'h01, {7'h00, irq}); // enabled event
      wr_reg(pbpc_pkg::ADDR_EVEN, 8'h00);
      #1 chk("irq", 8'h00, {7'h00, irq}); // masked
      wr_reg(pbpc_pkg::ADDR_INTCTL, 8'h08);
      rd_chk(pbpc_pkg::ADDR_INTCTL, 8'h09); // clear blocked
      rd_chk(pbpc_pkg::ADDR_PORT, 8'h22); // access
      wr_reg(pbpc_pkg::ADDR_INTCTL, 8'h08);
      wr_reg(pbpc_pkg::ADDR_EVCLR, 8'h03);
      rd_chk(pbpc_pkg::ADDR_INTCTL, 8'h08); // clear works
      rd_chk(pbpc_pkg::ADDR_EVSTAT, 8'h00); // status cleared
      ext_val <= 8'h62;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wr_reg(pbpc_pkg::ADDR_CHGEN, 8'hF0);
      wr_reg(pbpc_pkg::ADDR_INTCTL, 8'h08);
      repeat (2) @(posedge clk);
      rd_chk(pbpc_pkg::ADDR_INTCTL, 8'h09); // latch kept
      rd_chk(pbpc_pkg::ADDR_PORT, 8'h62);
      for (int e = 0; e < 2; e++) begin
         wr_reg(pbpc_pkg::ADDR_OPTION, {1'b1, e[0], 6'h3F});
         wr_reg(pbpc_pkg::ADDR_INTCTL, 8'h10);
         ext_val[0] <= ~e[0];
         repeat (3) @(posedge clk);
         rd_chk(pbpc_pkg::ADDR_INTCTL, 8'h10); // rising edge ignored in falling mode; no edge driven in rising mode
         ext_val[0] <= e[0];
         repeat (3) @(posedge clk);
         rd_chk(pbpc_pkg::ADDR_INTCTL, 8'h12); // edge taken
         #1 chk("ext", 8'h01, {7'h00, ext}); // request
      end
      prog <= 1'b1;
      ext_val <= 8'h81;
      repeat (3) @(posedge clk);
      #1 chk("prog", 8'h02, {6'h00, pdi, pci}); // data and clock
      wr_reg(pbpc_pkg::ADDR_OPTION, 8'h7F);
      #1 chk("pullup", 8'hFF, pu); // all enabled
      por <= 1'b1;
      @(posedge clk);
      por <= 1'b0;
      rd_chk(pbpc_pkg::ADDR_CHGEN, 8'h00); // cleared
      chk("pullup", 8'h00, pu); // disabled again
      report_and_stop();
   end
endmodule // pbpc_port_bench
